// ===== inc/scr_defines.svh
// Offsets, bit positions and reset values of the core special registers.
// Included by the register block; holds definitions only.
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

`define SCR_OFS_PORT0 8'h00
`define SCR_OFS_PTR0 8'h01
`define SCR_OFS_PORT1 8'h02
`define SCR_OFS_PTR1 8'h03
`define SCR_OFS_BANK 8'h04
`define SCR_OFS_WORK 8'h05
`define SCR_OFS_PCL 8'h06
`define SCR_OFS_TBLP 8'h07
`define SCR_OFS_TABLE_HIGH_BYTE_LATCH 8'h08
`define SCR_OFS_TBHP 8'h09
`define SCR_OFS_STATUS 8'h0a

`define SCR_PERIPH_FIRST 8'h0b
`define SCR_PERIPH_LAST 8'h4a
`define SCR_HOLE_A 8'h13
`define SCR_HOLE_B 8'h1b
`define SCR_HOLE_C 8'h1c
`define SCR_HOLE_D 8'h2a
`define SCR_GP_FIRST 8'h80
`define SCR_OFS_BANK1_CTRL 8'h40

`define SCR_BIT_CARRY 0
`define SCR_BIT_NIBBLE 1
`define SCR_BIT_ZERO 2
`define SCR_BIT_SIGN 3
`define SCR_BIT_SLEEP 4
`define SCR_BIT_WDT 5
`define SCR_BIT_BANK 0

`define SCR_RST_BYTE 8'h00
`define SCR_UNUSED_DATA 8'h00

`endif

// ===== inc/scr_pkg.sv
// Types shared by the core special register block and its ALU flag unit.
// Assumes one clock domain shared with the instruction execution logic.
package scr_pkg;

    typedef enum logic [3:0] {
        SCR_ALU_ADD,
        SCR_ALU_ADC,
        SCR_ALU_SUB,
        SCR_ALU_SBC,
        SCR_ALU_AND,
        SCR_ALU_OR,
        SCR_ALU_XOR,
        SCR_ALU_RLC,
        SCR_ALU_RRC,
        SCR_ALU_MOV
    } scr_alu_op_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scr_acc_req_t;

    typedef struct packed {
        logic valid;
        scr_alu_op_t op;
        logic [7:0] operand;
    } scr_alu_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scr_mem_req_t;

    typedef struct packed {
        logic sign_err;
        logic zero;
        logic nibble;
        logic carry;
    } scr_flags_t;

    typedef enum logic [1:0] {
        SCR_TBL_IDLE,
        SCR_TBL_FETCH,
        SCR_TBL_STORE
    } scr_tbl_state_t;

endpackage

// ===== src/scr_alu_flags.sv
// Adder and logic unit computing a result and the arithmetic flags.
// Purely combinational; the register block stores what it produces.
module scr_alu_flags
    import scr_pkg::*;
(
    input wire scr_alu_op_t op_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] operand_in,
    input wire logic carry_in,
    output logic [7:0] result_out,
    output scr_flags_t flags_out,
    output scr_flags_t update_out
);
    logic subtract;
    logic [7:0] addend;
    logic carry_seed;
    logic [8:0] full_sum;
    logic [4:0] low_sum;
    logic [7:0] low7_sum;

    always_comb begin
        subtract = (op_in == SCR_ALU_SUB) || (op_in == SCR_ALU_SBC);
        // Subtract as add of complement, so carry means no borrow
        addend = subtract ? ~operand_in : operand_in;
        carry_seed = (op_in == SCR_ALU_SUB) ? 1'b1 :
            ((op_in == SCR_ALU_ADC) || (op_in == SCR_ALU_SBC)) ?
            carry_in : 1'b0;
        full_sum = {1'b0, acc_in} + {1'b0, addend} + {8'h00, carry_seed};
        low_sum = {1'b0, acc_in[3:0]} + {1'b0, addend[3:0]}
            + {4'h0, carry_seed};
        low7_sum = {1'b0, acc_in[6:0]} + {1'b0, addend[6:0]}
            + {7'h00, carry_seed};
        result_out = full_sum[7:0];
        update_out = '0;
        // RQ14 carry out or no borrow
        flags_out.carry = full_sum[8];
        // RQ15 low nibble carry
        flags_out.nibble = low_sum[4];
        // RQ17 carry in differs from out
        flags_out.sign_err = low7_sum[7] ^ full_sum[8];
        unique case (op_in)
            SCR_ALU_ADD, SCR_ALU_ADC, SCR_ALU_SUB, SCR_ALU_SBC: begin
                update_out = '1;
            end
            SCR_ALU_AND: begin
                result_out = acc_in & operand_in;
                update_out.zero = 1'b1;
            end
            SCR_ALU_OR: begin
                result_out = acc_in | operand_in;
                update_out.zero = 1'b1;
            end
            SCR_ALU_XOR: begin
                result_out = acc_in ^ operand_in;
                update_out.zero = 1'b1;
            end
            // RQ14 rotate through carry
            SCR_ALU_RLC: begin
                result_out = {acc_in[6:0], carry_in};
                flags_out.carry = acc_in[7];
                update_out.carry = 1'b1;
            end
            SCR_ALU_RRC: begin
                result_out = {carry_in, acc_in[7:1]};
                flags_out.carry = acc_in[0];
                update_out.carry = 1'b1;
            end
            SCR_ALU_MOV: begin
                result_out = operand_in;
            end
            default: begin
                update_out = '0;
            end
        endcase
        // RQ16 zero result
        flags_out.zero = (result_out == 8'h00);
    end

endmodule // scr_alu_flags

// ===== src/scr_core_regs.sv
// Core special registers: pointers, indirect ports, bank select,
// working register, program counter low byte, table read and status.
// Assumes the execution logic shares clk_in and keeps requests off
// while acc_busy_out is high.
`include "scr_defines.svh"

// Function
// RQ1 - Reads of unused special locations return 00H.
// RQ2 - Indirect port access acts on location held in paired pointer.
// RQ3 - Port 0 reaches bank 0 only; port 1 uses bank select.
// RQ4 - Port register as target reads 00H; writes do nothing.
// RQ5 - Direct addressing always bank 0; other banks via pointer 1 only.
// RQ6 - Both pointers are real readable and writable storage.
// RQ7 - ALU results land in working register; no register-to-register move.
// RQ8 - Writing program counter low byte jumps within current page.
// RQ9 - Program counter low byte write inserts one dummy cycle.
// RQ10 - Table read: high byte to latch, low byte to chosen location.
// RQ11 - Status writes leave watchdog and sleep flags unchanged.
// RQ12 - Watchdog flag changes on power-up, time-out, clear or sleep.
// RQ13 - Sleep flag changes on sleep, watchdog clear or power-up.
// RQ14 - Carry: addition carry, no subtraction borrow, rotate through carry.
// RQ15 - Nibble carry from low nibble, or no borrow into it.
// RQ16 - Zero flag set when result is zero.
// RQ17 - Sign error when carry into top differs from carry out.
// RQ18 - Status layout: bits 5..0 as flags, bits 7 and 6 zero.
// RQ19 - Watchdog flag set by time-out; cleared by reset, clear, sleep.
// RQ20 - Sleep flag set by sleep; cleared by reset or watchdog clear.
// RQ21 - Bank select bit 0 picks bank for port 1 accesses.
// RQ22 - Flags not affected by an instruction keep their value.
module scr_core_regs
    import scr_pkg::*;
#(
    parameter int PROG_W = 16
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire scr_acc_req_t acc_req_in,
    output logic acc_busy_out,
    output logic [7:0] acc_rdata_out,
    output logic acc_rvalid_out,
    input wire scr_alu_req_t alu_req_in,
    input wire logic tbl_rd_in,
    input wire logic [7:0] tbl_dest_in,
    output logic [15:0] prog_addr_out,
    output logic prog_rd_out,
    input wire logic [PROG_W-1:0] prog_data_in,
    output scr_mem_req_t mem_req_out,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [7:0] pc_low_in,
    output logic pc_load_out,
    output logic [7:0] pc_target_out,
    output logic dummy_cycle_out,
    input wire logic wdt_timeout_in,
    input wire logic wdt_clear_in,
    input wire logic sleep_in,
    output logic [7:0] working_reg_out,
    output logic [7:0] status_out
);
    logic [7:0] pointer_0, pointer_1, working_register;
    logic [7:0] table_ptr_low, table_ptr_high, table_high_byte_latch;
    logic bank_choice_bit, watchdog_expired_flag, sleep_entered_flag;
    scr_flags_t arith, next_arith;
    logic [7:0] next_pointer_0, next_pointer_1, next_working_register;
    logic [7:0] next_table_ptr_low, next_table_ptr_high;
    logic next_bank_choice_bit, next_wdt, next_sleep;
    logic [7:0] status_word, int_rdata;

    // Access stage
    logic req_rd, req_wr, tgt_bank, is_int, is_ext, in_periph;
    logic [7:0] req_addr, req_wdata, tgt_addr;
    scr_mem_req_t next_mem_req;
    logic rd_pend, rd_ext, next_rd_pend, next_rd_ext;
    logic [7:0] rd_int_data, next_rd_int_data;
    logic [7:0] next_acc_rdata, next_pc_target;
    logic next_acc_rvalid, next_pc_load;

    // Table read
    scr_tbl_state_t tbl_state, next_tbl_state;
    logic [7:0] tbl_dest, tbl_low, next_tbl_dest, next_tbl_low;
    logic [7:0] next_table_high_byte_latch, prog_hi;
    logic [15:0] next_prog_addr;

    logic [7:0] alu_result;
    scr_flags_t alu_flags, alu_update;

    scr_alu_flags u_alu (
        .op_in(alu_req_in.op),
        .acc_in(working_register),
        .operand_in(alu_req_in.operand),
        .carry_in(arith.carry),
        .result_out(alu_result),
        .flags_out(alu_flags),
        .update_out(alu_update)
    );

    assign prog_hi = 8'(prog_data_in[PROG_W-1:8]);
    assign acc_busy_out = (tbl_state != SCR_TBL_IDLE);
    assign working_reg_out = working_register;
    assign status_out = status_word;

    // RQ18 status bit layout
    always_comb begin
        status_word = 8'h00;
        status_word[`SCR_BIT_WDT] = watchdog_expired_flag;
        status_word[`SCR_BIT_SLEEP] = sleep_entered_flag;
        status_word[`SCR_BIT_SIGN] = arith.sign_err;
        status_word[`SCR_BIT_ZERO] = arith.zero;
        status_word[`SCR_BIT_NIBBLE] = arith.nibble;
        status_word[`SCR_BIT_CARRY] = arith.carry;
    end

    always_comb begin
        // Table store owns the access path; core requests are ignored until idle
        if (tbl_state == SCR_TBL_STORE) begin
            req_rd = 1'b0;
            req_wr = 1'b1;
            req_addr = tbl_dest;
            req_wdata = tbl_low;
        end else if (tbl_state == SCR_TBL_IDLE) begin
            req_rd = acc_req_in.rd;
            req_wr = acc_req_in.wr;
            req_addr = acc_req_in.addr;
            req_wdata = acc_req_in.wdata;
        end else begin
            req_rd = 1'b0;
            req_wr = 1'b0;
            req_addr = 8'h00;
            req_wdata = 8'h00;
        end
        // RQ2 port goes through pointer
        // RQ3 port 0 bank 0, port 1 banked
        // RQ21 bank bit steers port 1
        // RQ5 direct always bank 0
        tgt_bank = (req_addr == `SCR_OFS_PORT1) ? bank_choice_bit : 1'b0;
        tgt_addr = (req_addr == `SCR_OFS_PORT0) ? pointer_0 :
            (req_addr == `SCR_OFS_PORT1) ? pointer_1 : req_addr;
        // RQ4 port as target is void
        is_int = !tgt_bank && (tgt_addr <= `SCR_OFS_STATUS)
            && (tgt_addr != `SCR_OFS_PORT0) && (tgt_addr != `SCR_OFS_PORT1);
        in_periph = (tgt_addr >= `SCR_PERIPH_FIRST)
            && (tgt_addr <= `SCR_PERIPH_LAST)
            && (tgt_addr != `SCR_HOLE_A) && (tgt_addr != `SCR_HOLE_B)
            && (tgt_addr != `SCR_HOLE_C) && (tgt_addr != `SCR_HOLE_D)
            && (tgt_addr != `SCR_OFS_BANK1_CTRL);
        is_ext = tgt_bank ? (tgt_addr == `SCR_OFS_BANK1_CTRL) :
            ((tgt_addr >= `SCR_GP_FIRST) || in_periph);
        // RQ1 unused reads zero
        int_rdata = `SCR_UNUSED_DATA;
        if (is_int) begin
            unique case (tgt_addr)
                `SCR_OFS_PTR0: int_rdata = pointer_0;
                `SCR_OFS_PTR1: int_rdata = pointer_1;
                `SCR_OFS_BANK: int_rdata = {7'h00, bank_choice_bit};
                `SCR_OFS_WORK: int_rdata = working_register;
                `SCR_OFS_PCL: int_rdata = pc_low_in;
                `SCR_OFS_TBLP: int_rdata = table_ptr_low;
                `SCR_OFS_TABLE_HIGH_BYTE_LATCH: int_rdata = table_high_byte_latch;
                `SCR_OFS_TBHP: int_rdata = table_ptr_high;
                `SCR_OFS_STATUS: int_rdata = status_word;
                default: int_rdata = `SCR_UNUSED_DATA;
            endcase
        end
        next_mem_req = '0;
        if ((req_rd || req_wr) && is_ext) begin
            next_mem_req = '{rd: req_rd, wr: req_wr, bank: tgt_bank,
                addr: tgt_addr, wdata: req_wdata};
        end
        next_rd_pend = req_rd;
        next_rd_ext = req_rd && is_ext;
        next_rd_int_data = int_rdata;
        next_acc_rvalid = rd_pend;
        next_acc_rdata = rd_ext ? mem_rdata_in : rd_int_data;
        // RQ8 jump within page
        // RQ9 one dummy cycle
        next_pc_load = req_wr && is_int && (tgt_addr == `SCR_OFS_PCL);
        next_pc_target = next_pc_load ? req_wdata : pc_target_out;
    end

    always_comb begin
        next_pointer_0 = pointer_0;
        next_pointer_1 = pointer_1;
        next_bank_choice_bit = bank_choice_bit;
        next_working_register = working_register;
        next_table_ptr_low = table_ptr_low;
        next_table_ptr_high = table_ptr_high;
        // RQ22 unaffected flags hold
        next_arith = arith;
        if (req_wr && is_int) begin
            unique case (tgt_addr)
                // RQ6 pointers are storage
                `SCR_OFS_PTR0: next_pointer_0 = req_wdata;
                `SCR_OFS_PTR1: next_pointer_1 = req_wdata;
                `SCR_OFS_BANK: next_bank_choice_bit = req_wdata[`SCR_BIT_BANK];
                `SCR_OFS_WORK: next_working_register = req_wdata;
                `SCR_OFS_TBLP: next_table_ptr_low = req_wdata;
                `SCR_OFS_TBHP: next_table_ptr_high = req_wdata;
                // RQ11 only arithmetic bits writable
                `SCR_OFS_STATUS: begin
                    next_arith.carry = req_wdata[`SCR_BIT_CARRY];
                    next_arith.nibble = req_wdata[`SCR_BIT_NIBBLE];
                    next_arith.zero = req_wdata[`SCR_BIT_ZERO];
                    next_arith.sign_err = req_wdata[`SCR_BIT_SIGN];
                end
                default: next_arith = arith;
            endcase
        end
        // RQ7 ALU result to working register
        if (alu_req_in.valid) begin
            next_working_register = alu_result;
            if (alu_update.carry) next_arith.carry = alu_flags.carry;
            if (alu_update.nibble) next_arith.nibble = alu_flags.nibble;
            if (alu_update.zero) next_arith.zero = alu_flags.zero;
            if (alu_update.sign_err) next_arith.sign_err = alu_flags.sign_err;
        end
        // RQ12 watchdog flag sources only
        // RQ19 time-out sets, clear or sleep clears
        next_wdt = watchdog_expired_flag;
        if (wdt_clear_in || sleep_in) next_wdt = 1'b0;
        if (wdt_timeout_in) next_wdt = 1'b1;
        // RQ13 sleep flag sources only
        // RQ20 sleep sets, watchdog clear clears
        next_sleep = sleep_entered_flag;
        if (wdt_clear_in) next_sleep = 1'b0;
        if (sleep_in) next_sleep = 1'b1;
    end

    // RQ10 table fetch and store
    always_comb begin
        next_tbl_state = tbl_state;
        next_tbl_dest = tbl_dest;
        next_tbl_low = tbl_low;
        next_table_high_byte_latch = table_high_byte_latch;
        next_prog_addr = prog_addr_out;
        unique case (tbl_state)
            SCR_TBL_IDLE: begin
                if (tbl_rd_in) begin
                    next_tbl_state = SCR_TBL_FETCH;
                    next_tbl_dest = tbl_dest_in;
                    next_prog_addr = {table_ptr_high, table_ptr_low};
                end
            end
            SCR_TBL_FETCH: begin
                next_table_high_byte_latch = prog_hi;
                next_tbl_low = prog_data_in[7:0];
                next_tbl_state = SCR_TBL_STORE;
            end
            SCR_TBL_STORE: next_tbl_state = SCR_TBL_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pointer_0 <= `SCR_RST_BYTE;
            pointer_1 <= `SCR_RST_BYTE;
            bank_choice_bit <= 1'b0;
            working_register <= `SCR_RST_BYTE;
            table_ptr_low <= `SCR_RST_BYTE;
            table_ptr_high <= `SCR_RST_BYTE;
            table_high_byte_latch <= `SCR_RST_BYTE;
            arith <= '0;
            watchdog_expired_flag <= 1'b0;
            sleep_entered_flag <= 1'b0;
            mem_req_out <= '0;
            rd_pend <= 1'b0;
            rd_ext <= 1'b0;
            rd_int_data <= `SCR_RST_BYTE;
            acc_rvalid_out <= 1'b0;
            acc_rdata_out <= `SCR_RST_BYTE;
            pc_load_out <= 1'b0;
            dummy_cycle_out <= 1'b0;
            pc_target_out <= `SCR_RST_BYTE;
            tbl_state <= SCR_TBL_IDLE;
            tbl_dest <= `SCR_RST_BYTE;
            tbl_low <= `SCR_RST_BYTE;
            prog_addr_out <= 16'h0000;
            prog_rd_out <= 1'b0;
        end else begin
            pointer_0 <= next_pointer_0;
            pointer_1 <= next_pointer_1;
            bank_choice_bit <= next_bank_choice_bit;
            working_register <= next_working_register;
            table_ptr_low <= next_table_ptr_low;
            table_ptr_high <= next_table_ptr_high;
            table_high_byte_latch <= next_table_high_byte_latch;
            arith <= next_arith;
            watchdog_expired_flag <= next_wdt;
            sleep_entered_flag <= next_sleep;
            mem_req_out <= next_mem_req;
            rd_pend <= next_rd_pend;
            rd_ext <= next_rd_ext;
            rd_int_data <= next_rd_int_data;
            acc_rvalid_out <= next_acc_rvalid;
            acc_rdata_out <= next_acc_rdata;
            pc_load_out <= next_pc_load;
            dummy_cycle_out <= next_pc_load;
            pc_target_out <= next_pc_target;
            tbl_state <= next_tbl_state;
            tbl_dest <= next_tbl_dest;
            tbl_low <= next_tbl_low;
            prog_addr_out <= next_prog_addr;
            prog_rd_out <= (next_tbl_state == SCR_TBL_FETCH);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_unused_read_zero: assert property ( // RQ1
        (!acc_busy_out && acc_req_in.rd && acc_req_in.addr == `SCR_HOLE_A)
        |-> ##2 (acc_rvalid_out && acc_rdata_out == 8'h00))
        else $error("unused location did not read zero");

    a_port_uses_pointer: assert property ( // RQ2
        (!acc_busy_out && acc_req_in.wr && acc_req_in.addr == `SCR_OFS_PORT1
        && (bank_choice_bit ? pointer_1 == `SCR_OFS_BANK1_CTRL
        : pointer_1 >= `SCR_GP_FIRST))
        |=> (mem_req_out.wr && mem_req_out.addr == $past(pointer_1)))
        else $error("indirect write missed pointer target");

    a_port0_bank_zero: assert property ( // RQ3
        (!acc_busy_out && (acc_req_in.rd || acc_req_in.wr)
        && acc_req_in.addr == `SCR_OFS_PORT0 && pointer_0 >= `SCR_GP_FIRST)
        |=> ((mem_req_out.rd || mem_req_out.wr) && !mem_req_out.bank))
        else $error("port 0 left bank 0");

    a_port_self_void: assert property ( // RQ4
        (!acc_busy_out && acc_req_in.rd && acc_req_in.addr == `SCR_OFS_PORT0
        && pointer_0 == `SCR_OFS_PORT1)
        |-> ##1 !mem_req_out.rd ##1 (acc_rvalid_out && acc_rdata_out == 8'h00))
        else $error("port register as target not void");

    a_direct_bank_zero: assert property ( // RQ5
        (!acc_busy_out && (acc_req_in.rd || acc_req_in.wr)
        && acc_req_in.addr >= `SCR_GP_FIRST)
        |=> ((mem_req_out.rd || mem_req_out.wr) && !mem_req_out.bank))
        else $error("direct access left bank 0");

    a_alu_to_working: assert property ( // RQ7
        (alu_req_in.valid && alu_req_in.op == SCR_ALU_MOV)
        |=> (working_register == $past(alu_req_in.operand)))
        else $error("move result not in working register");

    a_pcl_dummy: assert property ( // RQ9
        (!acc_busy_out && acc_req_in.wr && acc_req_in.addr == `SCR_OFS_PCL)
        |=> (pc_load_out && dummy_cycle_out
        && pc_target_out == $past(acc_req_in.wdata)) ##1 !dummy_cycle_out)
        else $error("low byte jump or dummy cycle wrong");

    a_table_latch: assert property ( // RQ10
        prog_rd_out |=> (tbl_state == SCR_TBL_STORE
        && table_high_byte_latch == $past(prog_hi)))
        else $error("table high byte not latched");

    a_status_protect: assert property ( // RQ11
        (!wdt_timeout_in && !wdt_clear_in && !sleep_in)
        |=> $stable({watchdog_expired_flag, sleep_entered_flag}))
        else $error("protected status flag changed");

    a_sleep_sets: assert property ( // RQ20
        sleep_in |=> (sleep_entered_flag && !watchdog_expired_flag
        || $past(wdt_timeout_in)))
        else $error("sleep entry flags wrong");

    a_flags_hold: assert property ( // RQ22
        (alu_req_in.valid && alu_req_in.op == SCR_ALU_MOV
        && !(req_wr && is_int && tgt_addr == `SCR_OFS_STATUS))
        |=> $stable(arith))
        else $error("unaffected flag changed");

endmodule // scr_core_regs

// ===== tb/scr_far_mem.sv
// Far side model: data memory banks and program memory.
// Assumes one-cycle requests from scr_core_regs on the shared clock.
module scr_far_mem
    import scr_pkg::*;
(
    input wire logic clk_in,
    input wire scr_mem_req_t mem_req_in,
    input wire logic [15:0] prog_addr_in,
    input wire logic prog_rd_in,
    output logic [7:0] mem_rdata_out,
    output logic [15:0] prog_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram [2][256];
    logic [7:0] last = 8'h00;
    logic [15:0] word;
    always @(posedge clk_in) begin
        if (mem_req_in.wr) begin
            ram[mem_req_in.bank][mem_req_in.addr] <= mem_req_in.wdata;
        end
        if (mem_req_in.rd) begin
            last <= mem_rdata_out;
        end
    end
    // Idle buses show inverted data so a stale sample cannot match
    always_comb begin
        word = {prog_addr_in[7:0] ^ 8'h5a, prog_addr_in[15:8] ^ 8'h3c};
        mem_rdata_out = ~last;
        if (mem_req_in.rd) begin
            mem_rdata_out = ram[mem_req_in.bank][mem_req_in.addr];
        end
        prog_data_out = prog_rd_in ? word : ~word;
    end
endmodule // scr_far_mem

// ===== tb/core_special_register_space_test.sv
// Self-checking bench for scr_core_regs with a behavioural model.
// Assumes scr_far_mem answers memory and program reads.
module core_special_register_space_test
    import scr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    scr_acc_req_t acc = '0;
    scr_alu_req_t alu = '0;
    logic tbl_rd = 1'b0;
    logic [7:0] dest = 8'h00;
    logic [7:0] prog_counter_low_byte = 8'h00;
    logic tmo = 1'b0;
    logic clr = 1'b0;
    logic slp = 1'b0;
    logic busy, rvalid, prd, pload, dummy;
    logic [7:0] rdata, mrdata, ptgt, wreg, stat;
    logic [15:0] paddr, pdata;
    scr_mem_req_t mreq;
    logic [7:0] holes [7] = '{8'h13, 8'h1b, 8'h1c, 8'h2a, 8'h40, 8'h4b, 8'h7f};
    int n_mismatch = 0;
    int total_checks = 0;
    int unsigned seed = 81;
    int st = 0;
    int m_acc = 0;
    int v, w;
    scr_core_regs u_scr_core_regs (.clk_in(clk_in), .reset_in(reset_in),
        .acc_req_in(acc), .acc_busy_out(busy), .acc_rdata_out(rdata),
        .acc_rvalid_out(rvalid), .alu_req_in(alu), .tbl_rd_in(tbl_rd),
        .tbl_dest_in(dest), .prog_addr_out(paddr), .prog_rd_out(prd),
        .prog_data_in(pdata), .mem_req_out(mreq), .mem_rdata_in(mrdata),
        .pc_low_in(prog_counter_low_byte), .pc_load_out(pload), .pc_target_out(ptgt),
        .dummy_cycle_out(dummy), .wdt_timeout_in(tmo), .wdt_clear_in(clr),
        .sleep_in(slp), .working_reg_out(wreg), .status_out(stat));
    scr_far_mem u_scr_far_mem (.clk_in(clk_in), .mem_req_in(mreq),
        .prog_addr_in(paddr), .prog_rd_in(prd), .mem_rdata_out(mrdata),
        .prog_data_out(pdata));
    always #20 clk_in = ~clk_in;
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed & 255;
    endfunction
    task automatic chk(logic [23:0] seen, logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge clk_in);
        acc <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_in);
        acc <= '0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, int exp);
        wr(1'b0, a, 8'h00);
        @(posedge clk_in);
        #1;
        chk({rvalid, rdata}, {1'b1, exp[7:0]});
    endtask
    task automatic ev(logic t, logic c, logic s);
        @(posedge clk_in);
        {tmo, clr, slp} <= {t, c, s};
        @(posedge clk_in);
        {tmo, clr, slp} <= 3'b000;
        #1;
        if (t) st |= 'h20; else if (c | s) st &= 'hdf;
        if (s) st |= 'h10; else if (c) st &= 'hef;
        chk(stat, st[7:0]);
    endtask
    task automatic alu_step(scr_alu_op_t op, int b);
        int a, c, bb, ci, s, r;
        a = m_acc;
        c = st & 1;
        bb = (op == SCR_ALU_SUB || op == SCR_ALU_SBC) ? (~b & 255) : b;
        ci = (op == SCR_ALU_ADC || op == SCR_ALU_SBC) ? c : op == SCR_ALU_SUB;
        s = a + bb + ci;
        case (op)
            SCR_ALU_AND: r = a & b;
            SCR_ALU_OR: r = a | b;
            SCR_ALU_XOR: r = a ^ b;
            SCR_ALU_RLC: r = (a << 1 | c) & 255;
            SCR_ALU_RRC: r = c << 7 | a >> 1;
            SCR_ALU_MOV: r = b;
            default: r = s & 255;
        endcase
        if (op <= SCR_ALU_SBC) st = st & 'h30 | (s >> 8)
            | (((a & 15) + (bb & 15) + ci) >> 4 & 1) << 1
            | (((a & 127) + (bb & 127) + ci) >> 7 ^ s >> 8) << 3;
        if (op == SCR_ALU_RLC || op == SCR_ALU_RRC)
            st = st & 'hfe | (op == SCR_ALU_RLC ? a >> 7 : a & 1);
        if (op != SCR_ALU_MOV && op < SCR_ALU_RLC)
            st = st & 'hfb | (r == 0) << 2;
        @(posedge clk_in);
        alu <= '{valid: 1'b1, op: op, operand: b[7:0]};
        @(posedge clk_in);
        alu <= '0;
        #1;
        m_acc = r;
        chk({wreg, stat}, {r[7:0], st[7:0]});
    endtask
    initial begin
        #200us;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        prog_counter_low_byte <= 8'(rnd());
        @(posedge clk_in);
        #1;
        chk({wreg, stat}, 16'h0000);
        foreach (holes[i]) rd(holes[i], 0);
        v = rnd();
        w = rnd();
        wr(1'b1, 8'h01, 8'h80);
        wr(1'b1, 8'h04, 8'h01);
        wr(1'b1, 8'h00, v[7:0]);
        chk(mreq, {3'b010, 8'h80, v[7:0]});
        wr(1'b1, 8'h03, 8'h40);
        wr(1'b1, 8'h02, w[7:0]);
        chk(mreq, {3'b011, 8'h40, w[7:0]});
        rd(8'h02, w);
        rd(8'h01, 'h80);
        rd(8'h03, 'h40);
        rd(8'h80, v);
        wr(1'b1, 8'h01, 8'h02);
        rd(8'h00, 0);
        wr(1'b1, 8'h00, 8'hff);
        chk(mreq, 0);
        wr(1'b1, 8'h04, 8'h00);
        wr(1'b1, 8'h03, 8'h80);
        rd(8'h02, v);
        wr(1'b1, 8'h0a, 8'hff);
        st = 'h0f;
        rd(8'h0a, st);
        ev(1'b0, 1'b0, 1'b1);
        ev(1'b1, 1'b0, 1'b0);
        wr(1'b1, 8'h0a, 8'h00);
        st &= 'h30;
        rd(8'h0a, st);
        ev(1'b0, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b1);
        m_acc = rnd();
        wr(1'b1, 8'h05, m_acc[7:0]);
        for (int i = 0; i < 60; i++) begin
            v = (i % 10 == 7 || i % 10 == 8) ? m_acc : int'(rnd());
            alu_step(scr_alu_op_t'(i % 10), v);
        end
        rd(8'h05, m_acc);
        v = rnd();
        wr(1'b1, 8'h06, v[7:0]);
        chk({pload, dummy, ptgt}, {2'b11, v[7:0]});
        @(posedge clk_in);
        #1;
        chk({pload, dummy}, 2'b00);
        rd(8'h06, prog_counter_low_byte);
        v = rnd();
        w = rnd();
        wr(1'b1, 8'h07, v[7:0]);
        wr(1'b1, 8'h09, w[7:0]);
        @(posedge clk_in);
        tbl_rd <= 1'b1;
        dest <= 8'h81;
        @(posedge clk_in);
        tbl_rd <= 1'b0;
        #1;
        chk({busy, prd, paddr}, {2'b11, w[7:0], v[7:0]});
        repeat (2) @(posedge clk_in);
        #1;
        chk(mreq, {3'b010, 8'h81, w[7:0] ^ 8'h3c});
        rd(8'h08, v ^ 'h5a);
        print_verdict();
    end
endmodule // core_special_register_space_test
